// >>> cms_defines.svh
// register offsets, field positions, reset values and timing for the measurement sequencer
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH
`define CMS_ADDR_ST1 8'h10
`define CMS_ADDR_XL 8'h11
`define CMS_ADDR_XH 8'h12
`define CMS_ADDR_YL 8'h13
`define CMS_ADDR_YH 8'h14
`define CMS_ADDR_ZL 8'h15
`define CMS_ADDR_ZH 8'h16
`define CMS_ADDR_LAST 8'h17
`define CMS_ADDR_ST2 8'h18
`define CMS_ADDR_SECOND_CONTROL_REGISTER 8'h31
`define CMS_ADDR_CNTL3 8'h32
`define CMS_ST1_DATA_READY_FLAG_BIT 0
`define CMS_ST1_SKIP_BIT 1
`define CMS_ST2_OVF_BIT 3
`define CMS_CNTL3_SOFT_RESET_BIT_BIT 0
`define CMS_MODE_RESET 5'h00
`define CMS_RESULT_RESET 16'h0000
`define CMS_CLK_MHZ 200
`define CMS_PERIOD1_US 100000
`define CMS_PERIOD2_US 50000
`define CMS_PERIOD3_US 20000
`define CMS_PERIOD4_US 10000
`define CMS_OVF_LIMIT_UT 4912
`define CMS_SENS_NT_PER_LSB 600
`define CMS_NT_PER_UT 1000
`endif

// >>> cms_pkg.sv
// types for the measurement sequencer
package cms_pkg;
  typedef enum logic [4:0] {
    CMS_MODE_PDN = 5'h00,
    CMS_MODE_SINGLE = 5'h01,
    CMS_MODE_CONT1 = 5'h02,
    CMS_MODE_CONT2 = 5'h04,
    CMS_MODE_CONT3 = 5'h06,
    CMS_MODE_CONT4 = 5'h08,
    CMS_MODE_SELFTEST = 5'h10,
    CMS_MODE_FUSE = 5'h1f
  } cms_mode_type;
  typedef enum logic [1:0] {
    CMS_ST_IDLE,
    CMS_ST_MEAS,
    CMS_ST_SLEEP
  } cms_state_type;
endpackage

// >>> cms_sequencer.sv
// measurement sequencer: reset sources, mode control, status flags, result protection
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "cms_defines.svh"
module cms_sequencer
  import cms_pkg::*;
#(
  parameter int unsigned PERIOD1_CYC = `CMS_PERIOD1_US * `CMS_CLK_MHZ,
  parameter int unsigned PERIOD2_CYC = `CMS_PERIOD2_US * `CMS_CLK_MHZ,
  parameter int unsigned PERIOD3_CYC = `CMS_PERIOD3_US * `CMS_CLK_MHZ,
  parameter int unsigned PERIOD4_CYC = `CMS_PERIOD4_US * `CMS_CLK_MHZ,
  parameter int unsigned DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_low,
  input wire logic iface_supply_on,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic conv_start,
  output logic conv_selftest,
  input wire logic conv_done,
  input wire logic [DATA_W-1:0] conv_x,
  input wire logic [DATA_W-1:0] conv_y,
  input wire logic [DATA_W-1:0] conv_z,
  input wire logic [7:0] conv_last,
  output logic fuse_power,
  output logic interval_sleep,
  output logic in_reset
);

  // pin synchronisers: level accepted when stages two and three agree
  logic [1:0] pin_raw;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_lvl_q;

  assign pin_raw = {iface_supply_on, reset_pin_low};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
          pin_s3_q[gi] <= 1'b0;
          pin_lvl_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_lvl_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // combined synchronous reset from pin, supply monitor and soft reset
  logic soft_rst_wr;
  logic soft_reset_bit_q;
  logic soft_reset_bit_d;

  assign soft_rst_wr = reg_wr && (reg_addr == `CMS_ADDR_CNTL3) &&
                       reg_wdata[`CMS_CNTL3_SOFT_RESET_BIT_BIT];
  assign soft_reset_bit_d = !pin_lvl_q[0] || !pin_lvl_q[1] || soft_rst_wr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_reset_bit_q <= 1'b1;
    end else begin
      soft_reset_bit_q <= soft_reset_bit_d;
    end
  end

  assign in_reset = soft_reset_bit_q;

  // register access decode
  logic wr_mode;
  logic rd_result;
  logic rd_st2;
  logic [4:0] wcode;
  logic code_meas;
  logic code_cont;
  logic [31:0] period_sel;

  assign wr_mode = reg_wr && !soft_reset_bit_q && (reg_addr == `CMS_ADDR_SECOND_CONTROL_REGISTER);
  assign rd_st2 = reg_rd && !soft_reset_bit_q && (reg_addr == `CMS_ADDR_ST2);
  assign rd_result = reg_rd && !soft_reset_bit_q && (reg_addr >= `CMS_ADDR_XL) &&
                     (reg_addr <= `CMS_ADDR_LAST);
  assign wcode = reg_wdata[4:0];

  always_comb begin
    code_meas = 1'b0;
    code_cont = 1'b0;
    period_sel = PERIOD1_CYC;
    case (wcode)
      CMS_MODE_SINGLE, CMS_MODE_SELFTEST: begin
        code_meas = 1'b1;
      end
      CMS_MODE_CONT1: begin
        code_cont = 1'b1;
        period_sel = PERIOD1_CYC;
      end
      CMS_MODE_CONT2: begin
        code_cont = 1'b1;
        period_sel = PERIOD2_CYC;
      end
      CMS_MODE_CONT3: begin
        code_cont = 1'b1;
        period_sel = PERIOD3_CYC;
      end
      CMS_MODE_CONT4: begin
        code_cont = 1'b1;
        period_sel = PERIOD4_CYC;
      end
      default: begin
        code_meas = 1'b0;
      end
    endcase
  end

  // mode sequencer
  cms_state_type state_q;
  logic [4:0] mode_q;
  logic [31:0] period_q;
  logic [31:0] cnt_q;
  logic start_meas;
  logic done_ev;

  assign done_ev = conv_done && (state_q == CMS_ST_MEAS);
  assign start_meas = (wr_mode && (code_meas || code_cont)) ||
                      ((state_q == CMS_ST_SLEEP) && (cnt_q >= period_q - 32'd1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= CMS_ST_IDLE;
      mode_q <= `CMS_MODE_RESET;
      period_q <= 32'd0;
    end else if (soft_reset_bit_q) begin
      state_q <= CMS_ST_IDLE;
      mode_q <= `CMS_MODE_RESET;
      period_q <= 32'd0;
    end else if (wr_mode) begin
      // unknown codes behave as power-down
      if (code_meas || code_cont || wcode == CMS_MODE_FUSE) begin
        mode_q <= wcode;
      end else begin
        mode_q <= CMS_MODE_PDN;
      end
      state_q <= (code_meas || code_cont) ? CMS_ST_MEAS : CMS_ST_IDLE;
      period_q <= period_sel;
    end else begin
      case (state_q)
        CMS_ST_IDLE: begin
          state_q <= CMS_ST_IDLE;
        end
        CMS_ST_MEAS: begin
          if (done_ev) begin
            if (mode_q == CMS_MODE_SINGLE || mode_q == CMS_MODE_SELFTEST) begin
              state_q <= CMS_ST_IDLE;
              mode_q <= CMS_MODE_PDN;
            end else begin
              state_q <= CMS_ST_SLEEP;
            end
          end
        end
        CMS_ST_SLEEP: begin
          if (start_meas) begin
            state_q <= CMS_ST_MEAS;
          end
        end
        default: begin
          state_q <= CMS_ST_IDLE;
        end
      endcase
    end
  end

  // period counter runs from each measurement start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'd0;
    end else if (soft_reset_bit_q || start_meas) begin
      cnt_q <= 32'd0;
    end else if (state_q != CMS_ST_IDLE) begin
      cnt_q <= cnt_q + 32'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_start <= 1'b0;
      conv_selftest <= 1'b0;
    end else begin
      // no start pulse in the cycle that enters reset
      conv_start <= start_meas && !soft_reset_bit_q && !soft_reset_bit_d;
      if (wr_mode) begin
        conv_selftest <= (wcode == CMS_MODE_SELFTEST);
      end else if (soft_reset_bit_q) begin
        conv_selftest <= 1'b0;
      end
    end
  end

  assign fuse_power = (mode_q == CMS_MODE_FUSE) && !soft_reset_bit_q;
  assign interval_sleep = (state_q == CMS_ST_SLEEP) && !soft_reset_bit_q;

  // read protection window
  logic prot_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prot_q <= 1'b0;
    end else if (soft_reset_bit_q || rd_st2) begin
      prot_q <= 1'b0;
    end else if (rd_result) begin
      prot_q <= 1'b1;
    end
  end

  // status flags; a hardware set wins over a read clear in the same cycle
  logic data_ready_flag_q;
  logic skip_q;
  logic ovf_q;
  logic store_ok;
  logic rd_start;
  logic [DATA_W:0] abs_x;
  logic [DATA_W:0] abs_y;
  logic [DATA_W:0] abs_z;
  logic [31:0] abs_sum;
  logic ovf_hit;

  assign store_ok = done_ev && !prot_q;
  assign rd_start = rd_result || rd_st2;

  function automatic logic [DATA_W:0] abs_val(input logic [DATA_W-1:0] v);
    logic [DATA_W:0] ext;
    ext = {v[DATA_W-1], v};
    abs_val = v[DATA_W-1] ? (~ext + 1'b1) : ext;
  endfunction

  assign abs_x = abs_val(conv_x);
  assign abs_y = abs_val(conv_y);
  assign abs_z = abs_val(conv_z);
  assign abs_sum = 32'(abs_x) + 32'(abs_y) + 32'(abs_z);
  assign ovf_hit = (abs_sum * 32'(`CMS_SENS_NT_PER_LSB)) >=
                   32'(`CMS_OVF_LIMIT_UT * `CMS_NT_PER_UT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_ready_flag_q <= 1'b0;
      skip_q <= 1'b0;
    end else if (soft_reset_bit_q) begin
      data_ready_flag_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      if (done_ev) begin
        data_ready_flag_q <= 1'b1;
      end else if (rd_start) begin
        data_ready_flag_q <= 1'b0;
      end
      if (done_ev && (prot_q || (data_ready_flag_q && !rd_start))) begin
        skip_q <= 1'b1;
      end else if (rd_start) begin
        skip_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else if (soft_reset_bit_q || start_meas) begin
      ovf_q <= 1'b0;
    end else if (store_ok && ovf_hit) begin
      ovf_q <= 1'b1;
    end
  end

  // result registers
  logic [DATA_W-1:0] res_x_q;
  logic [DATA_W-1:0] res_y_q;
  logic [DATA_W-1:0] res_z_q;
  logic [7:0] res_last_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_x_q <= `CMS_RESULT_RESET;
      res_y_q <= `CMS_RESULT_RESET;
      res_z_q <= `CMS_RESULT_RESET;
      res_last_q <= 8'h00;
    end else if (soft_reset_bit_q) begin
      res_x_q <= `CMS_RESULT_RESET;
      res_y_q <= `CMS_RESULT_RESET;
      res_z_q <= `CMS_RESULT_RESET;
      res_last_q <= 8'h00;
    end else if (store_ok) begin
      res_x_q <= conv_x;
      res_y_q <= conv_y;
      res_z_q <= conv_z;
      res_last_q <= conv_last;
    end
  end

  // read data, valid the cycle after the read strobe
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      `CMS_ADDR_ST1: begin
        rdata_d[`CMS_ST1_DATA_READY_FLAG_BIT] = data_ready_flag_q;
        rdata_d[`CMS_ST1_SKIP_BIT] = skip_q;
      end
      `CMS_ADDR_XL: rdata_d = res_x_q[7:0];
      `CMS_ADDR_XH: rdata_d = res_x_q[15:8];
      `CMS_ADDR_YL: rdata_d = res_y_q[7:0];
      `CMS_ADDR_YH: rdata_d = res_y_q[15:8];
      `CMS_ADDR_ZL: rdata_d = res_z_q[7:0];
      `CMS_ADDR_ZH: rdata_d = res_z_q[15:8];
      `CMS_ADDR_LAST: rdata_d = res_last_q;
      `CMS_ADDR_ST2: begin
        rdata_d[`CMS_ST2_OVF_BIT] = ovf_q;
      end
      `CMS_ADDR_SECOND_CONTROL_REGISTER: rdata_d = {3'h0, mode_q};
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= soft_reset_bit_q ? 8'h00 : rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// >>> cms_sequencer_properties.sv
// port assertions for the measurement sequencer
`timescale 1ns/1ps
module cms_sequencer_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_low,
  input wire logic iface_supply_on,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic conv_start,
  input wire logic conv_selftest,
  input wire logic fuse_power,
  input wire logic interval_sleep,
  input wire logic in_reset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a, logic [7:0] d);
    reg_wr && !in_reset && reg_addr == a && reg_wdata == d;
  endsequence
  a_single_start: assert property (s_wr(8'h31, 8'h01) |=> conv_start && !conv_selftest)
    else $error("single write gave no start");
  a_selftest_start: assert property (s_wr(8'h31, 8'h10) |=> conv_start && conv_selftest)
    else $error("self-test write gave no start");
  a_fuse_power: assert property (s_wr(8'h31, 8'h1f) |=> fuse_power && !conv_start)
    else $error("fuse power missing");
  a_pd_quiet: assert property (s_wr(8'h31, 8'h00) |-> ##2 (!conv_start && !fuse_power) [*8])
    else $error("activity after power-down");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_soft_reset: assert property (s_wr(8'h32, 8'h01) |=> in_reset ##1 !in_reset)
    else $error("soft reset pulse wrong");
  a_reset_quiet: assert property (in_reset |-> !conv_start && !fuse_power && !interval_sleep)
    else $error("activity in reset");
  a_supply_off: assert property (!iface_supply_on [*7] |-> in_reset)
    else $error("supply off without reset");
  a_pin_low: assert property (!reset_pin_low [*7] |-> in_reset)
    else $error("reset pin ignored");
endmodule
bind cms_sequencer cms_sequencer_properties i_cms_sequencer_properties (.clk, .rst,
  .reset_pin_low, .iface_supply_on, .reg_addr, .reg_wdata, .reg_wr, .conv_start,
  .conv_selftest, .fuse_power, .interval_sleep, .in_reset);

// >>> cms_frontend_model.sv
// conversion front end model answering each start with one result set
`timescale 1ns/1ps
module cms_frontend_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic conv_selftest,
  input wire logic [7:0] lat,
  input wire logic [15:0] d_in,
  output logic conv_done,
  output logic [15:0] conv_x,
  output logic [15:0] conv_y,
  output logic [15:0] conv_z,
  output logic [7:0] conv_last
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      conv_done <= 1'b0;
    end else begin
      conv_done <= cnt_q == 8'h01;
      if (conv_start) begin
        cnt_q <= lat;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  // result lines toggle outside the done cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {conv_x, conv_y, conv_z, conv_last} <= '0;
    end else if (cnt_q == 8'h01) begin
      {conv_x, conv_y, conv_z} <= {3{d_in}};
      conv_last <= {7'h00, conv_selftest};
    end else begin
      {conv_x, conv_y, conv_z, conv_last} <= ~{conv_x, conv_y, conv_z, conv_last};
    end
  end
endmodule

// >>> cms_sequencer_tb.sv
// self-checking bench for the measurement sequencer
`timescale 1ns/1ps
module cms_sequencer_tb;
  logic clk, rst, reset_pin_low, iface_supply_on, reg_wr, reg_rd, conv_start, conv_selftest;
  logic conv_done, fuse_power, interval_sleep, in_reset;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, conv_last, lat;
  logic [15:0] conv_x, conv_y, conv_z, d_in;
  int err_count, checked, n;
  cms_sequencer #(.PERIOD1_CYC(200), .PERIOD2_CYC(100), .PERIOD3_CYC(40), .PERIOD4_CYC(20))
    i_cms_sequencer (.clk, .rst, .reset_pin_low, .iface_supply_on, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .conv_start, .conv_selftest, .conv_done, .conv_x, .conv_y,
    .conv_z, .conv_last, .fuse_power, .interval_sleep, .in_reset);
  cms_frontend_model i_cms_frontend_model (.clk, .rst, .conv_start, .conv_selftest, .lat,
    .d_in, .conv_done, .conv_x, .conv_y, .conv_z, .conv_last);
  task chk(input logic [15:0] a, input logic [15:0] e);
    checked++;
    if (a !== e) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata & m}, {8'h00, e & m});
  endtask
  task wsig(input bit sel, output int c);
    c = 0;
    #1;
    while ((sel ? conv_done : conv_start) !== 1'b1 && c < 5000) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask
  task wdone;
    wsig(1'b1, n);
    chk(16'(n < 5000), 16'h1);
    @(posedge clk);
    #1;
  endtask
  task wait_rdy;
    n = 0;
    while (in_reset !== 1'b0 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n < 50), 16'h1);
  endtask
  task pdw;
    wr(8'h31, 8'h00);
    repeat (20000) @(posedge clk);
  endtask
  task t_reset;
    wait_rdy;
    rd(8'h10, 8'h00);
    rd(8'h31, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h31, 8'h03);
    rd(8'h31, 8'h00);
  endtask
  task t_single;
    d_in <= 16'h0100;
    wr(8'h31, 8'h01);
    wdone;
    rd(8'h31, 8'h00);
    rd(8'h10, 8'h01);
    rd(8'h14, 8'h01);
    rd(8'h18, 8'h00);
    rd(8'h10, 8'h00);
    d_in <= 16'hf557;
    wr(8'h31, 8'h01);
    wdone;
    wr(8'h31, 8'h01);
    rd(8'h10, 8'h01);
    wdone;
    rd(8'h10, 8'h03);
    rd(8'h18, 8'h08);
    rd(8'h10, 8'h00);
    d_in <= 16'h0100;
    wr(8'h31, 8'h01);
    rd(8'h16, 8'hf5);
    rd(8'h18, 8'h00);
    wdone;
    rd(8'h16, 8'h01);
    rd(8'h18, 8'h00);
  endtask
  task t_cont;
    logic [7:0] codes[4];
    int pers[4];
    codes = '{8'h02, 8'h04, 8'h06, 8'h08};
    pers = '{200, 100, 40, 20};
    pdw;
    lat <= 8'd8;
    for (int i = 0; i < 4; i++) begin
      wr(8'h31, codes[i]);
      wsig(1'b0, n);
      @(posedge clk);
      wsig(1'b0, n);
      chk(16'(n + 1), 16'(pers[i]));
    end
    wr(8'h31, 8'h02);
    wdone;
    rd(8'h11, 8'h00);
    d_in <= 16'hf557;
    wdone;
    chk(16'(interval_sleep), 16'h1);
    rd(8'h10, 8'h02, 8'h02);
    rd(8'h11, 8'h00);
    rd(8'h18, 8'h00);
    wdone;
    rd(8'h11, 8'h57);
    rd(8'h18, 8'h08);
    wr(8'h31, 8'h00);
    wsig(1'b0, n);
    chk(16'(n), 16'd5000);
  endtask
  task t_modes;
    pdw;
    wr(8'h31, 8'h10);
    wdone;
    rd(8'h17, 8'h01);
    rd(8'h31, 8'h00);
    rd(8'h18, 8'h08);
    pdw;
    wr(8'h31, 8'h1f);
    #1 chk(16'(fuse_power), 16'h1);
    wr(8'h31, 8'h00);
    #1 chk(16'(fuse_power), 16'h0);
  endtask
  task t_rst;
    pdw;
    wr(8'h31, 8'h01);
    wdone;
    wr(8'h32, 8'h01);
    #1 chk(16'(in_reset), 16'h1);
    wait_rdy;
    rd(8'h10, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(8'h31, 8'h02);
      @(posedge clk) {iface_supply_on, reset_pin_low} <= k ? 2'b01 : 2'b10;
      repeat (10) @(posedge clk);
      #1 chk(16'(in_reset), 16'h1);
      @(posedge clk) {iface_supply_on, reset_pin_low} <= 2'b11;
      wait_rdy;
      rd(8'h31, 8'h00);
    end
  endtask
  task summarize;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #490000;
    err_count++;
    summarize;
  end
  initial begin
    {rst, reset_pin_low, iface_supply_on} = 3'b111;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    lat = 8'd60;
    d_in = 16'h0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_single;
    t_cont;
    t_modes;
    t_rst;
    summarize;
  end
endmodule
